// >>> io_port_controller.sv
// general-purpose i/o port controller: 21 pins in three ports
`timescale 1ns/100ps
module io_port_controller
  import io_port_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  // cpu access
  input  wire logic                cpuWrByte,
  input  wire logic                cpuWrBit,
  input  wire cpu_target_t         cpuTarget,
  input  wire logic [1:0]          cpuPort,
  input  wire logic [2:0]          cpuBitIdx,
  input  wire logic                cpuBitVal,
  input  wire logic [7:0]          cpuWrData,
  input  wire logic                cpuRmw,
  output logic      [7:0]          cpuRdData,
  // interrupt configuration
  input  wire logic [2:0]          edgeFalling,
  input  wire logic [1:0]          portZeroNibbleMask,
  input  wire logic [7:0]          portOneBitMask,
  input  wire logic                portTwoMask,
  input  wire logic                portZeroIrqEnable,
  input  wire logic                portOneIrqEnable,
  input  wire logic                portTwoIrqEnable,
  output logic [2:0]               portIrq,
  output logic                     wakeUp,
  output logic                     portZeroDmaTrigger,
  output logic                     portOneDmaTrigger,
  // power modes and peripheral placement
  input  wire logic                deepSleepModeA,
  input  wire logic                deepSleepModeB,
  input  wire logic [7:0]          peripheralLocationConfig,
  input  wire logic [NSLOT-1:0]    periphOut,
  input  wire logic [NSLOT-1:0]    periphOe,
  output logic      [NSLOT-1:0]    periphIn,
  // pins
  input  wire logic [NUM_PINS-1:0] padIn,
  output logic      [NUM_PINS-1:0] padOut,
  output logic      [NUM_PINS-1:0] padOe,
  output logic      [NUM_PINS-1:0] padPullUp
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [23:0]         latch_ff;     // output latches
  logic [23:0]         fsel_ff;      // function select
  logic [23:0]         dir_ff;       // direction
  logic [23:0]         inp_ff;       // pull disable
  logic [23:0]         flag_ff;      // interrupt flags
  logic [7:0]          rdData_ff;    // read data
  logic [2:0]          irq_ff;       // port requests
  logic                dma0_ff;      // port 0 dma pulse
  logic                dma1_ff;      // port 1 dma pulse
  logic [NUM_PINS-1:0] padOut_ff;    // pin output level
  logic [NUM_PINS-1:0] padOe_ff;     // pin output enable
  logic [NUM_PINS-1:0] padPull_ff;   // pin pull enable

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pinLevel;     // filtered levels
  logic [NUM_PINS-1:0] pinRise;      // rising pulses
  logic [NUM_PINS-1:0] pinFall;      // falling pulses

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      pin_input_sync #(.RESET_LEVEL(1'b1)) u_sync (
        .clk    (clk),
        .rst    (rst),
        .pinRaw (padIn[gi]),
        .level  (pinLevel[gi]),
        .rise   (pinRise[gi]),
        .fall   (pinFall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // cpu write decode
  // ----------------------------------------------------------------
  wire        wrAny   = cpuWrByte | cpuWrBit;         // any write
  wire [4:0]  bitPos  = {cpuPort, cpuBitIdx};         // flat bit index
  wire [23:0] byteMsk = 24'h00_00FF << {cpuPort, 3'b000};
  wire [23:0] bitMsk  = 24'h00_0001 << bitPos;
  wire [23:0] wrMask  = (cpuWrByte ? byteMsk : bitMsk) & VALID_MASK;
  wire [23:0] wrVal   = cpuWrByte ? {3{cpuWrData}} : {24{cpuBitVal}};
  wire        wrData  = wrAny & (cpuTarget == TGT_DATA);
  wire        wrFsel  = wrAny & (cpuTarget == TGT_FSEL);
  wire        wrDir   = wrAny & (cpuTarget == TGT_DIR);
  wire        wrInp   = wrAny & (cpuTarget == TGT_INP);
  wire        wrFlag  = wrAny & (cpuTarget == TGT_FLAG);

  // bit writes merge into the stored value, never the pin level
  wire [23:0] nxt_latch = (latch_ff & ~wrMask) | (wrVal & wrMask);
  wire [23:0] nxt_fsel  = (fsel_ff & ~wrMask) | (wrVal & wrMask);
  wire [23:0] nxt_dir   = (dir_ff & ~wrMask) | (wrVal & wrMask);
  wire [23:0] nxt_inp   = (inp_ff & ~wrMask) | (wrVal & wrMask);

  // ----------------------------------------------------------------
  // pin events
  // ----------------------------------------------------------------
  wire [23:0] level24 = {3'b000, pinLevel};
  wire [23:0] rise24  = {3'b000, pinRise};
  wire [23:0] fall24  = {3'b000, pinFall};
  wire [23:0] gpioIn  = ~fsel_ff & ~dir_ff & VALID_MASK;   // gpio inputs
  wire [23:0] fallSel = {{8{edgeFalling[2]}}, {8{edgeFalling[1]}},
                         {8{edgeFalling[0]}}};
  wire [23:0] edgeHit = (fallSel & fall24) | (~fallSel & rise24);
  wire [23:0] flagSet = edgeHit & gpioIn;
  wire [23:0] flagClr = wrFlag ? (wrMask & ~wrVal) : 24'h00_0000;
  wire [23:0] nxt_flag = (flag_ff & ~flagClr) | flagSet;   // set wins

  // per-pin masks laid out over the three lanes
  wire [23:0] mask24 = {{8{portTwoMask}}, portOneBitMask,
                        {4{portZeroNibbleMask[1]}},
                        {4{portZeroNibbleMask[0]}}};
  wire [23:0] pend   = flag_ff & mask24 & VALID_MASK;
  wire [2:0]  portEn = {portTwoIrqEnable, portOneIrqEnable,
                        portZeroIrqEnable};
  wire [2:0]  nxt_irq = {|pend[23:16], |pend[15:8], |pend[7:0]} & portEn;

  // transitions on gpio inputs feed the dma triggers
  wire [23:0] trans  = (rise24 | fall24) & gpioIn;

  // ----------------------------------------------------------------
  // read path: pins normally, latch during read-modify-write
  // ----------------------------------------------------------------
  logic [23:0] rdSrc;   // selected register lane set
  always_comb begin
    case (cpuTarget)
      TGT_DATA: rdSrc = cpuRmw ? latch_ff : level24;
      TGT_FSEL: rdSrc = fsel_ff;
      TGT_DIR:  rdSrc = dir_ff;
      TGT_INP:  rdSrc = inp_ff;
      TGT_FLAG: rdSrc = flag_ff;
      default:  rdSrc = 24'h00_0000;
    endcase
  end
  wire [7:0] rdByte = (cpuPort == 2'd3) ? 8'h00 : rdSrc[{cpuPort, 3'b000} +: 8];

  // ----------------------------------------------------------------
  // peripheral placement and pin drive selection
  // ----------------------------------------------------------------
  logic [23:0]      drvOut;     // wanted output level
  logic [23:0]      drvOe;      // wanted output enable
  logic [23:0]      perOut;     // peripheral output per pin
  logic [23:0]      perOe;      // peripheral enable per pin
  logic [NSLOT-1:0] nxt_pIn;    // pin level seen by each slot
  always_comb begin
    int unsigned pin;
    pin     = 0;
    perOut  = 24'h00_0000;
    perOe   = 24'h00_0000;
    nxt_pIn = '0;
    // last assignment wins, so slot 0 has top priority
    for (int s = NSLOT - 1; s >= 0; s--) begin
      pin = peripheralLocationConfig[SLOT_LOC[s]] ? SLOT_PIN_B[s]
                                                  : SLOT_PIN_A[s];
      nxt_pIn[s] = level24[pin];
      if (fsel_ff[pin]) begin
        perOut[pin] = periphOut[s];
        perOe[pin]  = periphOe[s];
      end
    end
    // gpio pins take latch and direction, peripheral pins the unit
    drvOut = (fsel_ff & perOut) | (~fsel_ff & latch_ff);
    drvOe  = (fsel_ff & perOe) | (~fsel_ff & dir_ff);
  end
  assign periphIn = nxt_pIn;

  // pull only on undriven pins that keep their pull, never high drive
  wire [23:0] pullWant = ~drvOe & ~inp_ff & ~HIGH_DRIVE;
  wire        asleep   = deepSleepModeA | deepSleepModeB;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= LATCH_RST;
      fsel_ff  <= FSEL_RST;
      dir_ff   <= DIR_RST;
      inp_ff   <= INP_RST;
    end else begin
      if (wrData) latch_ff <= nxt_latch;
      if (wrFsel) fsel_ff  <= nxt_fsel;
      if (wrDir)  dir_ff   <= nxt_dir;
      if (wrInp)  inp_ff   <= nxt_inp;
    end
  end

  // ----------------------------------------------------------------
  // flags, requests, dma pulses, read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_ff   <= FLAG_RST;
      irq_ff    <= 3'b000;
      dma0_ff   <= 1'b0;
      dma1_ff   <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      flag_ff   <= nxt_flag;
      irq_ff    <= nxt_irq;
      dma0_ff   <= |trans[7:0];
      dma1_ff   <= |trans[15:8];
      rdData_ff <= rdByte;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, frozen while in either deep sleep mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      padOut_ff  <= LATCH_RST[20:0];
      padOe_ff   <= DIR_RST[20:0];
      padPull_ff <= PULL_RST;
    end else if (!asleep) begin
      padOut_ff  <= drvOut[20:0];
      padOe_ff   <= drvOe[20:0];
      padPull_ff <= pullWant[20:0];
    end
  end

  assign padOut             = padOut_ff;
  assign padOe              = padOe_ff;
  assign padPullUp          = padPull_ff;
  assign cpuRdData          = rdData_ff;
  assign portIrq            = irq_ff;
  assign wakeUp             = |irq_ff;
  assign portZeroDmaTrigger = dma0_ff;
  assign portOneDmaTrigger  = dma1_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // any accepted edge on a gpio input, whatever the cpu writes alongside
  sequence sClearWithEdge;
    flagSet != 24'h00_0000;
  endsequence

  // single-bit zero write to a flag with no edge on that pin
  sequence sPlainClear;
    wrFlag && cpuWrBit && !cpuWrByte && !cpuBitVal && !flagSet[bitPos] && VALID_MASK[bitPos];
  endsequence

  a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
    sClearWithEdge |=> (flag_ff & $past(flagSet)) == $past(flagSet))
    else $error("flag lost when edge met clear");

  a_zero_clears_flag: assert property (@(posedge clk) disable iff (rst)
    sPlainClear |=> !flag_ff[$past(bitPos)])
    else $error("flag not cleared by zero write");

  a_edge_sets_flag: assert property (@(posedge clk) disable iff (rst)
    flagSet[11] |=> flag_ff[11])
    else $error("configured edge did not set flag");

  a_reset_gpio_in: assert property (@(posedge clk)
    $past(rst) |-> (fsel_ff == 24'h00_0000) && (padOe == 21'h00_0000))
    else $error("pins not gpio inputs after reset");

  a_read_pins: assert property (@(posedge clk) disable iff (rst)
    (cpuTarget == TGT_DATA) && !cpuRmw && (cpuPort == 2'd1)
      |=> cpuRdData == $past(pinLevel[15:8]))
    else $error("read did not return pin levels");

  a_rmw_latch: assert property (@(posedge clk) disable iff (rst)
    (cpuTarget == TGT_DATA) && cpuRmw && (cpuPort == 2'd1) && !wrData
      |=> cpuRdData == latch_ff[15:8])
    else $error("rmw read did not return latch");

  a_sleep_holds_pins: assert property (@(posedge clk) disable iff (rst)
    asleep ##1 asleep |-> $stable(padOe) && $stable(padOut))
    else $error("pins changed during deep sleep");

  a_high_drive_nopull: assert property (@(posedge clk) disable iff (rst)
    padPullUp[9:8] == 2'b00)
    else $error("high-drive pin pulled");

  a_irq_gated: assert property (@(posedge clk) disable iff (rst)
    !portOneIrqEnable |=> !portIrq[1])
    else $error("disabled port raised request");

  a_irq_from_flag: assert property (@(posedge clk) disable iff (rst)
    portZeroIrqEnable && portZeroNibbleMask[1] && flag_ff[5] |=> portIrq[0] ##0 wakeUp)
    else $error("masked flag did not request");

  a_dma_on_input: assert property (@(posedge clk) disable iff (rst)
    trans[11] |=> portOneDmaTrigger ##1 (portOneDmaTrigger == $past(|trans[15:8])))
    else $error("dma trigger missed transition");

  a_output_drive: assert property (@(posedge clk) disable iff (rst)
    !asleep && dir_ff[10] && !fsel_ff[10] |=> padOe[10] && padOut[10] == $past(latch_ff[10]))
    else $error("gpio output not driven");

endmodule

// >>> io_port_pkg.sv
// shared constants for the general-purpose i/o port block
package io_port_pkg;

  // ----------------------------------------------------------------
  // pin and port geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS  = 21;           // usable pins
  localparam int unsigned NUM_PORTS = 3;            // ports 0..2
  localparam int unsigned VEC_W     = 24;           // three byte lanes
  localparam logic [23:0] VALID_MASK = 24'h1F_FFFF; // port 2 bits 7:5 unused
  localparam logic [23:0] HIGH_DRIVE = 24'h00_0300; // port 1 pins 0 and 1

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] LATCH_RST = 24'h1F_FFFF;  // output latches all ones
  localparam logic [23:0] FSEL_RST  = 24'h00_0000;  // all pins gpio
  localparam logic [23:0] DIR_RST   = 24'h00_0000;  // all pins input
  localparam logic [23:0] INP_RST   = 24'h00_0000;  // all inputs pulled up except the high-drive pins
  localparam logic [23:0] FLAG_RST  = 24'h00_0000;  // no pending flags
  localparam logic [20:0] PULL_RST  = 21'h1F_FCFF;  // pull on except high drive

  // ----------------------------------------------------------------
  // cpu access targets
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_DATA = 3'b000,   // port data / output latch
    TGT_FSEL = 3'b001,   // pin_function_select
    TGT_DIR  = 3'b010,   // pin_direction_select
    TGT_INP  = 3'b011,   // input_pull_mode
    TGT_FLAG = 3'b100    // pin_interrupt_flags
  } cpu_target_t;

  // ----------------------------------------------------------------
  // peripheral_location_config bit positions
  // ----------------------------------------------------------------
  localparam int unsigned LOC_SERIAL0 = 0;
  localparam int unsigned LOC_SERIAL1 = 1;
  localparam int unsigned LOC_TIMER4  = 4;
  localparam int unsigned LOC_TIMER3  = 5;
  localparam int unsigned LOC_TIMER1  = 6;

  // ----------------------------------------------------------------
  // peripheral signal slots: serial0 0-3, serial1 4-7, timer1 8-10,
  // timer3 11-12, timer4 13-14; lower slot wins a shared pin
  // ----------------------------------------------------------------
  localparam int unsigned NSLOT = 15;
  localparam int unsigned SLOT_PIN_A [NSLOT] =
    '{2, 3, 4, 5, 2, 3, 4, 5, 2, 3, 4, 11, 12, 8, 9};
  localparam int unsigned SLOT_PIN_B [NSLOT] =
    '{12, 13, 10, 11, 12, 13, 14, 15, 10, 9, 8, 14, 15, 16, 19};
  localparam int unsigned SLOT_LOC [NSLOT] =
    '{0, 0, 0, 0, 1, 1, 1, 1, 6, 6, 6, 5, 5, 4, 4};

endpackage

// >>> pin_input_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pin_input_sync
  import io_port_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinRaw,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_ff;      // first stage, read only by s2
  logic s2_ff;      // second stage
  logic s3_ff;      // third stage
  logic level_ff;   // accepted level
  logic nxt_level;  // level after agreement check

  // ------------------------------------------------------------
  // a change is accepted once stages two and three agree
  // ------------------------------------------------------------
  assign nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;

  // synchroniser chain
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff    <= RESET_LEVEL;
      s2_ff    <= RESET_LEVEL;
      s3_ff    <= RESET_LEVEL;
      level_ff <= RESET_LEVEL;
    end else begin
      s1_ff    <= pinRaw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  // one-cycle edge pulses, a cycle before level shows the new value
  assign level = level_ff;
  assign rise  = nxt_level & ~level_ff;
  assign fall  = ~nxt_level & level_ff;

endmodule

// >>> io_pin_partner.sv
// external devices on the pins: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module io_pin_partner
  import io_port_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [NUM_PINS-1:0] padOut,
  input  wire logic [NUM_PINS-1:0] padOe,
  input  wire logic [NUM_PINS-1:0] padPullUp,
  input  wire logic [NUM_PINS-1:0] extEn,
  input  wire logic [NUM_PINS-1:0] extVal,
  output logic      [NUM_PINS-1:0] padIn
);
  logic floatPat_ff; // an undriven, unpulled line wanders every cycle

  initial floatPat_ff = 1'b0;
  // toggle the floating pattern
  always @(posedge clk) begin
    floatPat_ff <= ~floatPat_ff;
  end

  // wire level from every party's drive
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (padOe[i] && extEn[i]) padIn[i] = 1'bx;        // contention
      else if (padOe[i]) padIn[i] = padOut[i];         // block drives
      else if (extEn[i]) padIn[i] = extVal[i];         // device drives
      else if (padPullUp[i]) padIn[i] = 1'b1;          // pulled up
      else padIn[i] = floatPat_ff;                     // floating
    end
  end
endmodule

// >>> io_port_controller_bench.sv
// self-checking bench for the i/o port controller
`timescale 1ns/100ps
module io_port_controller_bench;
  import io_port_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic                clk, rst, cpuWrByte, cpuWrBit, cpuBitVal, cpuRmw, portTwoMask;
  logic                deepSleepModeA, deepSleepModeB, wakeUp, portZeroDmaTrigger, portOneDmaTrigger;
  cpu_target_t         cpuTarget;
  logic [1:0]          cpuPort, portZeroNibbleMask;
  logic [2:0]          cpuBitIdx, edgeFalling, irqEn, portIrq;
  logic [7:0]          cpuWrData, cpuRdData, portOneBitMask, peripheralLocationConfig;
  logic [NSLOT-1:0]    periphOut, periphOe, periphIn;
  logic [NUM_PINS-1:0] padIn, padOut, padOe, padPullUp, extEn, extVal;
  int                  num_errors, n_tests, dma0, dma1;
  localparam int PL_SLOT [5] = '{0, 0, 7, 11, 14}; // placement cases
  localparam bit PL_ALT  [5] = '{0, 1, 1, 1, 1};
  localparam bit PL_VAL  [5] = '{0, 1, 0, 1, 1};   // opposite of the latch bit

  io_port_controller dut (
    .clk(clk), .rst(rst), .cpuWrByte(cpuWrByte), .cpuWrBit(cpuWrBit), .cpuTarget(cpuTarget),
    .cpuPort(cpuPort), .cpuBitIdx(cpuBitIdx), .cpuBitVal(cpuBitVal), .cpuWrData(cpuWrData),
    .cpuRmw(cpuRmw), .cpuRdData(cpuRdData), .edgeFalling(edgeFalling),
    .portZeroNibbleMask(portZeroNibbleMask), .portOneBitMask(portOneBitMask), .portTwoMask(portTwoMask),
    .portZeroIrqEnable(irqEn[0]), .portOneIrqEnable(irqEn[1]), .portTwoIrqEnable(irqEn[2]),
    .portIrq(portIrq), .wakeUp(wakeUp), .portZeroDmaTrigger(portZeroDmaTrigger),
    .portOneDmaTrigger(portOneDmaTrigger), .deepSleepModeA(deepSleepModeA), .deepSleepModeB(deepSleepModeB),
    .peripheralLocationConfig(peripheralLocationConfig), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn), .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp)
  );
  io_pin_partner pins (
    .clk(clk), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp), .extEn(extEn), .extVal(extVal),
    .padIn(padIn)
  );

  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count dma pulses at the sampling edge
  always @(posedge clk) begin
    if (portZeroDmaTrigger === 1'b1) dma0++;
    if (portOneDmaTrigger === 1'b1) dma1++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one write cycle, byte or single bit (bit value from d[0])
  task automatic wr(input cpu_target_t t, input int p, input logic bitMode, input int idx, input logic [7:0] d);
    @(negedge clk);
    cpuTarget = t;
    cpuPort = 2'(p);
    cpuBitIdx = 3'(idx);
    cpuWrData = d;
    cpuBitVal = d[0];
    cpuWrByte = ~bitMode;
    cpuWrBit = bitMode;
    @(negedge clk);
    cpuWrByte = 1'b0;
    cpuWrBit = 1'b0;
  endtask
  // read one byte; the answer lands one edge later
  task automatic rdc(input cpu_target_t t, input int p, input logic rmw, input logic [7:0] e);
    @(negedge clk);
    cpuTarget = t;
    cpuPort = 2'(p);
    cpuRmw = rmw;
    @(negedge clk);
    chk(24'(cpuRdData), 24'(e));
    cpuRmw = 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(24'({padOe, 3'h0}), 24'h00_0000);
    chk(24'(padOut), 24'h1F_FFFF);
    chk(24'(padPullUp), 24'h1F_FCFF);
    chk(24'(portIrq), 24'h00_0000);
    for (int p = 0; p < 3; p++) begin
      rdc(TGT_FSEL, p, 1'b0, 8'h00);
      rdc(TGT_DIR, p, 1'b0, 8'h00);
    end
    $display("reset test done");
  endtask
  task automatic t_pull();
    extEn[7:0] = 8'hFF; // keep port 0 from floating
    wr(TGT_INP, 0, 1'b0, 0, 8'hFF);
    wr(TGT_INP, 1, 1'b0, 0, 8'h03);
    cyc(1);
    chk(24'(padPullUp[15:0]), 24'h00_FC00);
    wr(TGT_INP, 0, 1'b0, 0, 8'h00);
    wr(TGT_INP, 1, 1'b0, 0, 8'h00);
    cyc(1);
    chk(24'(padPullUp[15:0]), 24'h00_FCFF);
    $display("pull test done");
  endtask
  // edge on one pin, flag, masking, enable and clear
  task automatic t_irq(input int p, input int b, input logic rising);
    int pin;
    pin = p * 8 + b;
    edgeFalling[p] = ~rising;
    extVal[pin] = ~rising;
    extEn[pin] = 1'b1;
    cyc(8);
    dma0 = 0;
    dma1 = 0;
    rdc(TGT_FLAG, p, 1'b0, 8'h00);
    extVal[pin] = rising;
    cyc(8);
    rdc(TGT_FLAG, p, 1'b0, 8'(1 << b));
    chk(24'(portIrq), 24'h00_0000);
    chk(24'({dma1[3:0], dma0[3:0]}), 24'((p == 1) ? 8'h10 : (p == 0) ? 8'h01 : 8'h00));
    irqEn = 3'h0;
    if (p == 0) portZeroNibbleMask[b / 4] = 1'b1;
    else if (p == 1) portOneBitMask[b] = 1'b1;
    else portTwoMask = 1'b1;
    cyc(3);
    chk(24'(portIrq), 24'h00_0000);
    irqEn[p] = 1'b1;
    cyc(3);
    chk(24'({wakeUp, portIrq}), 24'(8'h08 | (1 << p)));
    wr(TGT_FLAG, p, 1'b1, b, 8'h00);
    cyc(3);
    chk(24'({wakeUp, portIrq}), 24'h00_0000);
    extEn[pin] = 1'b0;
    portZeroNibbleMask = 2'h0;
    portOneBitMask = 8'h00;
    portTwoMask = 1'b0;
    cyc(8);
    rdc(TGT_FLAG, p, 1'b0, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_dir();
    dma1 = 0;
    wr(TGT_DIR, 1, 1'b0, 0, 8'hFC);
    wr(TGT_DATA, 1, 1'b0, 0, 8'hA5);
    wr(TGT_DATA, 1, 1'b1, 2, 8'h00);
    cyc(1);
    chk(24'({padOe[15:8], padOut[15:8]}), 24'h00_FCA1);
    cyc(5);
    rdc(TGT_DATA, 1, 1'b0, 8'hA3);
    rdc(TGT_DATA, 1, 1'b1, 8'hA1);
    chk(24'(dma1), 24'h00_0000);
    wr(TGT_DATA, 2, 1'b0, 0, 8'hE0);
    rdc(TGT_DATA, 2, 1'b1, 8'h00);
    rdc(TGT_DATA, 2, 1'b0, 8'h1F);
    rdc(TGT_DATA, 3, 1'b0, 8'h00);
    $display("direction test done");
  endtask
  task automatic t_periph();
    int s, pin;
    extEn[7:0] = 8'h00; // port 0 falls back on its pull-ups
    for (int i = 0; i < 5; i++) begin
      s = PL_SLOT[i];
      pin = PL_ALT[i] ? SLOT_PIN_B[s] : SLOT_PIN_A[s];
      dma0 = 0;
      dma1 = 0;
      peripheralLocationConfig = 8'h00;
      peripheralLocationConfig[SLOT_LOC[s]] = PL_ALT[i];
      periphOe[s] = 1'b1;
      periphOut[s] = PL_VAL[i];
      wr(TGT_FSEL, pin / 8, 1'b1, pin % 8, 8'h01);
      cyc(6);
      chk(24'({padOe[pin], padOut[pin], periphIn[s]}), 24'({1'b1, PL_VAL[i], PL_VAL[i]}));
      chk(24'(dma0 + dma1), 24'h00_0000);
      periphOe[s] = 1'b0;
      wr(TGT_FSEL, pin / 8, 1'b1, pin % 8, 8'h00);
      cyc(6);
    end
    rdc(TGT_FLAG, 0, 1'b0, 8'h00);
    peripheralLocationConfig = 8'h00;
    $display("placement test done");
  endtask
  task automatic t_sleep();
    for (int m = 0; m < 2; m++) begin
      deepSleepModeA = (m == 0);
      deepSleepModeB = (m == 1);
      wr(TGT_DATA, 1, 1'b0, 0, 8'h5A);
      wr(TGT_DIR, 1, 1'b0, 0, 8'h00);
      cyc(3);
      chk(24'({padOe[15:10], padOut[15:8]}), 24'h00_3FA1);
      deepSleepModeA = 1'b0;
      deepSleepModeB = 1'b0;
      cyc(3);
      chk(24'({padOe[15:10], padOut[15:8]}), 24'h00_005A);
      wr(TGT_DIR, 1, 1'b0, 0, 8'hFC);
      wr(TGT_DATA, 1, 1'b0, 0, 8'hA1);
      cyc(2);
    end
    $display("sleep test done");
  endtask

  // main sequence
  initial begin
    {rst, cpuWrByte, cpuWrBit, cpuBitVal, cpuRmw, portTwoMask, deepSleepModeA, deepSleepModeB} = 8'h80;
    cpuTarget = TGT_DATA;
    {cpuPort, portZeroNibbleMask, cpuBitIdx, cpuWrData, portOneBitMask} = 23'h00_0000;
    edgeFalling = 3'h7;
    irqEn = 3'h7;
    peripheralLocationConfig = 8'h00;
    {periphOut, periphOe} = 30'h0000_0000;
    extEn = 21'h00_0300; // hold the unpulled high-drive pins
    extVal = 21'h1F_FFFF;
    {num_errors, n_tests, dma0, dma1} = 128'h0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_pull();
    t_irq(0, 5, 1'b0);
    t_irq(1, 3, 1'b1);
    t_irq(2, 4, 1'b0);
    t_dir();
    t_periph();
    t_sleep();
    complete_run();
  end
  // watchdog: well beyond the expected run of under a thousand cycles
  initial begin
    #(10000 * 50);
    num_errors++;
    complete_run();
  end
endmodule
